// ==== core/lrx_pkg.sv ====
// constants and types for the link recovery exit and management message checker
//
// Operation
// - send own link reset within 5 ms of receiving the remote link reset
// - disable local port within 5 ms of later of link reset sent or received
// - enable local port within 5 ms of later of disable seen or port disabled
// - first exit action clears the port operational flag
// - next set window size to 1 and ack timeout within 100 to 200 us
// - then enter privileged mode so application frames are discarded
// - then start the alert process with the exit's alert code
// - last exit action restarts the affected port
// - message checks run: unknown, unsupported, short, route id, tag, context, reserved
// - unrecognised message code raises unknown-message alert without further parsing
// - supported-but-unimplemented code or wrong frame type raises unknown-message alert
// - message shorter than its type length raises too-short alert
// - longer message than specified is accepted without error
// - responder with unknown reply route id sends nothing and raises alert
// - out-of-context message discarded; configurator logs, responder ignores
// - valid message with reserved content still parsed and answered per type
// - node query gets normal reply; node query reply gets none
// - listed request types with reserved content answered with invalid-field response
// - async reply with reserved content: no reply, stop resend, clear alert data
package lrx_pkg;
    // timing: 5 ms paths, ack timeout chosen in the 100..200 us window
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned PATH_LIMIT_US = 5000;
    localparam int unsigned PATH_LIMIT_CYC = PATH_LIMIT_US * (CLK_HZ / 1000000);
    localparam int unsigned ACK_TMO_US = 150;
    localparam int unsigned ACK_TMO_CYC = ACK_TMO_US * (CLK_HZ / 1000000);
    localparam logic [7:0] WINDOW_AFTER_EXIT = 8'h01;
    localparam logic [7:0] WINDOW_RESET = 8'h08;
    localparam logic [15:0] ACK_TMO_RESET = 16'h0000;

    // message codes
    typedef enum logic [3:0] {
        MC_QUERY_NODE = 4'h0, MC_QUERY_NODE_REPLY = 4'h1, MC_CONFIGURE_PORT = 4'h2,
        MC_RESPONSE = 4'h3, MC_ASYNC_ALERT = 4'h4, MC_MASTER_ALERT = 4'h5,
        MC_QUIESCE = 4'h6, MC_ASYNC_REPLY = 4'h7, MC_QUERY_PROTOCOL = 4'h8,
        MC_QUERY_PROTOCOL_REPLY = 4'h9, MC_QUERY_PORT = 4'hA, MC_QUERY_PORT_REPLY = 4'hB,
        MC_DATA_READY = 4'hC, MC_DATA_REPLY = 4'hD, MC_DATA_REQUEST = 4'hE, MC_UNKNOWN = 4'hF
    } lrx_code_e;

    // verdicts of the message checker
    typedef enum logic [2:0] {
        VD_ACCEPT = 3'h0, VD_ALERT = 3'h1, VD_NO_REPLY = 3'h2, VD_DISCARD = 3'h3,
        VD_INVALID_FIELD = 3'h4, VD_LOG = 3'h5
    } lrx_verdict_e;

    // alert codes raised by the checker
    localparam logic [7:0] AC_UNKNOWN_MSG = 8'h20;
    localparam logic [7:0] AC_TOO_SHORT = 8'h21;
    localparam logic [7:0] AC_BAD_ROUTE = 8'h22;

    // recovery exit sequencer states
    typedef enum logic [2:0] {
        EX_IDLE = 3'h0, EX_CLR_OPER = 3'h1, EX_WINDOW = 3'h2, EX_PRIV = 3'h3,
        EX_ALERT = 3'h4, EX_RESTART = 3'h5
    } lrx_exit_e;
endpackage

// ==== core/lrx_core.sv ====
// link recovery path timing, unsuccessful-exit sequencer and management message checker
`timescale 1ns/1ps
module lrx_core #(
    parameter int unsigned PATH_LIMIT = lrx_pkg::PATH_LIMIT_CYC,
    parameter int unsigned LEN_W = 6
) (
    // clock and control
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // recovery events from the link
    input wire logic LINK_RESET_RX,
    input wire logic LINK_RESET_TX_DONE,
    input wire logic DISABLE_CHARS_SEEN,
    input wire logic PORT_DISABLED,
    input wire logic ERP_FAIL,
    input wire logic [7:0] ERP_FAIL_CODE,
    // recovery actions
    output logic SEND_LINK_RESET,
    output logic DISABLE_PORT,
    output logic ENABLE_PORT,
    output logic PATH_TIMEOUT,
    output logic OPERATIONAL,
    output logic [7:0] WINDOW_SIZE,
    output logic [15:0] ACK_TIMEOUT,
    output logic PRIVILEGED,
    output logic EXIT_ALERT_START,
    output logic [7:0] EXIT_ALERT_CODE,
    output logic PORT_RESTART,
    // received message and its context
    input wire logic MSG_VALID,
    input wire logic [3:0] MSG_CODE,
    input wire logic MSG_SUPPORTED,
    input wire logic MSG_FRAME_TYPE_OK,
    input wire logic [LEN_W-1:0] MSG_LEN,
    input wire logic [LEN_W-1:0] MSG_MIN_LEN,
    input wire logic ROUTE_ID_KNOWN,
    input wire logic TAG_OK,
    input wire logic IN_CONTEXT,
    input wire logic RESERVED_SET,
    input wire logic IS_CONFIGURATOR,
    // checker results
    output logic CHK_DONE,
    output logic [2:0] CHK_VERDICT,
    output logic [7:0] CHK_ALERT_CODE,
    output logic CHK_NORMAL_REPLY,
    output logic CHK_MASTER_ALERT,
    output logic CHK_CANCEL_IO,
    output logic CHK_CLEAR_ALERT
);
    import lrx_pkg::*;

    // ****************************************
    // recovery path timers
    // ****************************************
    logic [22:0] tx_cnt_r, dis_cnt_r, en_cnt_r;
    logic tx_arm_r, dis_arm_r, en_arm_r;
    logic rr_seen_r, rs_seen_r, dc_seen_r, pd_seen_r;

    // answer to remote link reset at once; the timer only guards a stalled transmitter
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            tx_arm_r <= 1'b0;
            tx_cnt_r <= 23'h000000;
            SEND_LINK_RESET <= 1'b0;
        end
        else if (CE)
        begin
            SEND_LINK_RESET <= LINK_RESET_RX && !tx_arm_r;
            if (LINK_RESET_RX && !tx_arm_r)
            begin
                tx_arm_r <= 1'b1;
                tx_cnt_r <= 23'h000000;
            end
            else if (tx_arm_r)
            begin
                if (LINK_RESET_TX_DONE)
                    tx_arm_r <= 1'b0;
                tx_cnt_r <= tx_cnt_r + 23'h000001;
            end
        end
    end

    // disable after the later of reset sent and reset received
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rr_seen_r <= 1'b0;
            rs_seen_r <= 1'b0;
            dis_arm_r <= 1'b0;
            dis_cnt_r <= 23'h000000;
            DISABLE_PORT <= 1'b0;
        end
        else if (CE)
        begin
            DISABLE_PORT <= 1'b0;
            if (LINK_RESET_RX)
                rr_seen_r <= 1'b1;
            if (LINK_RESET_TX_DONE)
                rs_seen_r <= 1'b1;
            if ((rr_seen_r || LINK_RESET_RX) && (rs_seen_r || LINK_RESET_TX_DONE) && !dis_arm_r)
            begin
                dis_arm_r <= 1'b1;
                dis_cnt_r <= 23'h000000;
                DISABLE_PORT <= 1'b1;
                rr_seen_r <= 1'b0;
                rs_seen_r <= 1'b0;
            end
            else if (dis_arm_r)
            begin
                if (PORT_DISABLED)
                    dis_arm_r <= 1'b0;
                dis_cnt_r <= dis_cnt_r + 23'h000001;
            end
        end
    end

    // enable after the later of disable characters seen and local port disabled
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            dc_seen_r <= 1'b0;
            pd_seen_r <= 1'b0;
            en_arm_r <= 1'b0;
            en_cnt_r <= 23'h000000;
            ENABLE_PORT <= 1'b0;
        end
        else if (CE)
        begin
            ENABLE_PORT <= 1'b0;
            if (DISABLE_CHARS_SEEN)
                dc_seen_r <= 1'b1;
            if (PORT_DISABLED)
                pd_seen_r <= 1'b1;
            if ((dc_seen_r || DISABLE_CHARS_SEEN) && (pd_seen_r || PORT_DISABLED))
            begin
                ENABLE_PORT <= 1'b1;
                en_arm_r <= 1'b1;
                en_cnt_r <= 23'h000000;
                dc_seen_r <= 1'b0;
                pd_seen_r <= 1'b0;
            end
            else if (en_arm_r)
            begin
                en_arm_r <= 1'b0;
                en_cnt_r <= en_cnt_r + 23'h000001;
            end
        end
    end

    // flags a path that overran its limit so the link layer can see it
    always_ff @(posedge CLK)
    begin
        if (RST)
            PATH_TIMEOUT <= 1'b0;
        else if (CE)
            PATH_TIMEOUT <= (tx_arm_r && tx_cnt_r >= 23'(PATH_LIMIT)) ||
                            (dis_arm_r && dis_cnt_r >= 23'(PATH_LIMIT));
    end

    // ****************************************
    // unsuccessful exit sequencer
    // ****************************************
    lrx_exit_e ex_r;
    logic [7:0] code_r;

    // one action per cycle, strictly in order; a new failure mid-sequence is ignored
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ex_r <= EX_IDLE;
            code_r <= 8'h00;
            OPERATIONAL <= 1'b1;
            WINDOW_SIZE <= WINDOW_RESET;
            ACK_TIMEOUT <= ACK_TMO_RESET;
            PRIVILEGED <= 1'b0;
            EXIT_ALERT_START <= 1'b0;
            EXIT_ALERT_CODE <= 8'h00;
            PORT_RESTART <= 1'b0;
        end
        else if (CE)
        begin
            EXIT_ALERT_START <= 1'b0;
            PORT_RESTART <= 1'b0;
            case (ex_r)
                EX_IDLE:
                begin
                    if (ERP_FAIL)
                    begin
                        code_r <= ERP_FAIL_CODE;
                        ex_r <= EX_CLR_OPER;
                    end
                end
                EX_CLR_OPER:
                begin
                    OPERATIONAL <= 1'b0;
                    ex_r <= EX_WINDOW;
                end
                EX_WINDOW:
                begin
                    WINDOW_SIZE <= WINDOW_AFTER_EXIT;
                    ACK_TIMEOUT <= 16'(ACK_TMO_CYC);
                    ex_r <= EX_PRIV;
                end
                EX_PRIV:
                begin
                    PRIVILEGED <= 1'b1;
                    ex_r <= EX_ALERT;
                end
                EX_ALERT:
                begin
                    EXIT_ALERT_START <= 1'b1;
                    EXIT_ALERT_CODE <= code_r;
                    ex_r <= EX_RESTART;
                end
                EX_RESTART:
                begin
                    PORT_RESTART <= 1'b1;
                    ex_r <= EX_IDLE;
                end
                default:
                    ex_r <= EX_IDLE;
            endcase
        end
    end

    // ****************************************
    // management message checker
    // ****************************************
    // single-cycle verdict; the first failing check in order decides
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            CHK_DONE <= 1'b0;
            CHK_VERDICT <= VD_ACCEPT;
            CHK_ALERT_CODE <= 8'h00;
            CHK_NORMAL_REPLY <= 1'b0;
            CHK_MASTER_ALERT <= 1'b0;
            CHK_CANCEL_IO <= 1'b0;
            CHK_CLEAR_ALERT <= 1'b0;
        end
        else if (CE)
        begin
            CHK_DONE <= MSG_VALID;
            CHK_ALERT_CODE <= 8'h00;
            CHK_NORMAL_REPLY <= 1'b0;
            CHK_MASTER_ALERT <= 1'b0;
            CHK_CANCEL_IO <= 1'b0;
            CHK_CLEAR_ALERT <= 1'b0;
            CHK_VERDICT <= VD_ACCEPT;
            if (MSG_VALID)
            begin
                if (MSG_CODE == MC_UNKNOWN)
                begin
                    CHK_VERDICT <= VD_ALERT;
                    CHK_ALERT_CODE <= AC_UNKNOWN_MSG;
                end
                else if (!MSG_SUPPORTED || !MSG_FRAME_TYPE_OK)
                begin
                    CHK_VERDICT <= VD_ALERT;
                    CHK_ALERT_CODE <= AC_UNKNOWN_MSG;
                end
                else if (MSG_LEN < MSG_MIN_LEN) // longer is fine
                begin
                    CHK_VERDICT <= VD_ALERT;
                    CHK_ALERT_CODE <= AC_TOO_SHORT;
                end
                else if (!IS_CONFIGURATOR && !ROUTE_ID_KNOWN)
                begin
                    CHK_VERDICT <= VD_ALERT;
                    CHK_ALERT_CODE <= AC_BAD_ROUTE;
                end
                else if (IS_CONFIGURATOR && !TAG_OK)
                    CHK_VERDICT <= VD_DISCARD;
                else if (!IN_CONTEXT)
                    CHK_VERDICT <= IS_CONFIGURATOR ? VD_LOG : VD_DISCARD;
                else if (RESERVED_SET)
                begin
                    case (lrx_code_e'(MSG_CODE))
                        MC_QUERY_NODE:
                        begin
                            CHK_VERDICT <= VD_ACCEPT;
                            CHK_NORMAL_REPLY <= 1'b1;
                        end
                        MC_QUERY_NODE_REPLY:
                            CHK_VERDICT <= VD_NO_REPLY;
                        MC_ASYNC_ALERT:
                        begin
                            CHK_VERDICT <= VD_INVALID_FIELD;
                            CHK_MASTER_ALERT <= 1'b1;
                        end
                        MC_ASYNC_REPLY:
                        begin
                            CHK_VERDICT <= VD_NO_REPLY;
                            CHK_CLEAR_ALERT <= 1'b1;
                        end
                        MC_RESPONSE, MC_QUERY_PROTOCOL_REPLY, MC_QUERY_PORT_REPLY:
                            CHK_VERDICT <= VD_DISCARD;
                        MC_DATA_READY, MC_DATA_REQUEST:
                        begin
                            CHK_VERDICT <= VD_DISCARD;
                            CHK_CANCEL_IO <= 1'b1;
                        end
                        default:
                            CHK_VERDICT <= VD_INVALID_FIELD;
                    endcase
                end
                else
                    CHK_NORMAL_REPLY <= 1'b1;
            end
        end
    end
endmodule

// ==== sim/lrx_monitor.sv ====
// port-level checker for the recovery paths, exit walk and message verdicts
`timescale 1ns/1ps
module lrx_monitor
    import lrx_pkg::*;
#(
    parameter int unsigned PATH_LIMIT = 20,
    parameter int unsigned LEN_W = 6
) (
    // recovery side
    input wire logic CLK, RST, CE, LINK_RESET_RX, LINK_RESET_TX_DONE, DISABLE_CHARS_SEEN, PORT_DISABLED, ERP_FAIL,
    input wire logic SEND_LINK_RESET, DISABLE_PORT, ENABLE_PORT, OPERATIONAL, PRIVILEGED, EXIT_ALERT_START,
    input wire logic PORT_RESTART,
    input wire logic [7:0] WINDOW_SIZE,
    input wire logic [15:0] ACK_TIMEOUT,
    // message side
    input wire logic MSG_VALID, MSG_SUPPORTED, MSG_FRAME_TYPE_OK, ROUTE_ID_KNOWN, TAG_OK, IN_CONTEXT,
    input wire logic RESERVED_SET, IS_CONFIGURATOR, CHK_DONE, CHK_NORMAL_REPLY,
    input wire logic [3:0] MSG_CODE,
    input wire logic [LEN_W-1:0] MSG_LEN,
    input wire logic [LEN_W-1:0] MSG_MIN_LEN,
    input wire logic [2:0] CHK_VERDICT,
    input wire logic [7:0] CHK_ALERT_CODE
);
    // ****************************************
    // check ladder stages
    // ****************************************
    logic ok_code;
    logic ok_len;
    logic ok_src;
    assign ok_code = MSG_VALID && MSG_CODE != 4'hF && MSG_SUPPORTED && MSG_FRAME_TYPE_OK;
    assign ok_len = ok_code && MSG_LEN >= MSG_MIN_LEN;
    assign ok_src = ok_len && (IS_CONFIGURATOR ? TAG_OK : ROUTE_ID_KNOWN);

    default clocking cb @(posedge CLK); endclocking
    // a frozen block answers nothing, so attempts that meet a low enable are dropped
    default disable iff (RST || !CE);

    a_link_reset_cause: assert property ($rose(SEND_LINK_RESET) |-> $past(LINK_RESET_RX))
        else $error("link reset request without a received reset");
    a_disable_cause: assert property (DISABLE_PORT |-> $past(LINK_RESET_RX || LINK_RESET_TX_DONE))
        else $error("port disable without a reset frame event");
    a_enable_cause: assert property (ENABLE_PORT |-> $past(DISABLE_CHARS_SEEN || PORT_DISABLED))
        else $error("port enable without a disable event");
    a_oper_first: assert property (ERP_FAIL && OPERATIONAL && !PRIVILEGED |->
        ##[1:3] (!OPERATIONAL && !PRIVILEGED && WINDOW_SIZE == WINDOW_RESET))
        else $error("operational flag not cleared first");
    a_window_ack: assert property ($fell(OPERATIONAL) |=>
        WINDOW_SIZE == WINDOW_AFTER_EXIT && ACK_TIMEOUT == ACK_TMO_CYC && !PRIVILEGED)
        else $error("window or ack timeout wrong after exit");
    a_priv_alert_order: assert property ($rose(PRIVILEGED) |->
        !EXIT_ALERT_START ##1 EXIT_ALERT_START ##1 (PORT_RESTART && !EXIT_ALERT_START))
        else $error("privileged, alert and restart out of order");
    a_restart_last: assert property (PORT_RESTART |-> $past(EXIT_ALERT_START) && PRIVILEGED && !OPERATIONAL)
        else $error("restart not after the alert");
    a_chk_answer: assert property (MSG_VALID |=> CHK_DONE)
        else $error("no verdict for a message");
    a_unknown_alert: assert property (MSG_VALID && !ok_code |=>
        CHK_VERDICT == VD_ALERT && CHK_ALERT_CODE == AC_UNKNOWN_MSG)
        else $error("unknown message not alerted");
    a_short_alert: assert property (ok_code && !ok_len |=>
        CHK_VERDICT == VD_ALERT && CHK_ALERT_CODE == AC_TOO_SHORT)
        else $error("short message not alerted");
    a_route_alert: assert property (ok_len && !IS_CONFIGURATOR && !ROUTE_ID_KNOWN |=>
        CHK_VERDICT == VD_ALERT && CHK_ALERT_CODE == AC_BAD_ROUTE)
        else $error("bad reply route not alerted");
    a_context_drop: assert property (ok_src && !IN_CONTEXT |=>
        CHK_VERDICT == ($past(IS_CONFIGURATOR) ? VD_LOG : VD_DISCARD))
        else $error("out of context message not dropped");
    a_accept_long: assert property (ok_src && IN_CONTEXT && !RESERVED_SET |=>
        CHK_VERDICT == VD_ACCEPT && CHK_NORMAL_REPLY)
        else $error("valid message not accepted");
endmodule
bind lrx_core lrx_monitor #(.PATH_LIMIT(PATH_LIMIT), .LEN_W(LEN_W)) u_lrx_monitor (.*);

// ==== sim/lrx_remote.sv ====
// model of the remote port and the link events seen by the block during recovery
`timescale 1ns/1ps
module lrx_remote (
    // clock, reset and scenario control
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic dup_rx,
    input wire logic [7:0] dly,
    // action from the block
    input wire logic disable_port,
    // events towards the block
    output logic link_reset_rx,
    output logic tx_done,
    output logic port_dis,
    output logic dis_seen
);
    // ****************************************
    // recovery walk
    // ****************************************
    initial {link_reset_rx, tx_done, port_dis, dis_seen} = 4'h0;
    always
    begin
        @(posedge clk iff (go && !rst));
        #1 link_reset_rx = 1'b1;
        @(posedge clk);
        // a repeated frame while ours is pending must not raise a second request
        #1 link_reset_rx = dup_rx;
        @(posedge clk);
        #1 link_reset_rx = 1'b0;
        // long delays let the path timer run out
        repeat (dly) @(posedge clk);
        #1 tx_done = 1'b1;
        @(posedge clk);
        #1 tx_done = 1'b0;
        @(posedge clk iff disable_port);
        repeat (dly) @(posedge clk);
        #1 port_dis = 1'b1;
        @(posedge clk);
        #1 port_dis = 1'b0;
        repeat (dly) @(posedge clk);
        #1 dis_seen = 1'b1;
        @(posedge clk);
        #1 dis_seen = 1'b0;
    end
endmodule

// ==== sim/lrx_core_tb.sv ====
// self-checking bench for the recovery exit and message checker block
`timescale 1ns/1ps
module lrx_core_tb;
    import lrx_pkg::*;
    logic CLK = 1'b0, RST = 1'b1, CE = 1'b1, ERP_FAIL = 1'b0, MSG_VALID = 1'b0, MSG_SUPPORTED = 1'b0;
    logic MSG_FRAME_TYPE_OK = 1'b0, ROUTE_ID_KNOWN = 1'b0, TAG_OK = 1'b0, IN_CONTEXT = 1'b0, RESERVED_SET = 1'b0;
    logic IS_CONFIGURATOR = 1'b0, go = 1'b0, dup = 1'b0;
    logic [7:0] ERP_FAIL_CODE = 8'h00, dly = 8'h02;
    logic [3:0] MSG_CODE = 4'h0;
    logic [5:0] MSG_LEN = 6'h00, MSG_MIN_LEN = 6'h00;
    logic LINK_RESET_RX, LINK_RESET_TX_DONE, DISABLE_CHARS_SEEN, PORT_DISABLED, SEND_LINK_RESET, DISABLE_PORT;
    logic ENABLE_PORT, PATH_TIMEOUT, OPERATIONAL, PRIVILEGED, EXIT_ALERT_START, PORT_RESTART, CHK_DONE;
    logic CHK_NORMAL_REPLY, CHK_MASTER_ALERT, CHK_CANCEL_IO, CHK_CLEAR_ALERT;
    logic [7:0] WINDOW_SIZE, EXIT_ALERT_CODE, CHK_ALERT_CODE;
    logic [15:0] ACK_TIMEOUT;
    logic [2:0] CHK_VERDICT;
    logic [31:0] seed = 32'h1D12D41E, r;
    int errors = 0, checks_done = 0, n_send = 0, n_rst = 0, n_to = 0;

    always #4 CLK = ~CLK;
    always @(posedge CLK) if (SEND_LINK_RESET === 1'b1) n_send++;
    always @(posedge CLK) if (PORT_RESTART === 1'b1) n_rst++;
    always @(posedge CLK) if (PATH_TIMEOUT === 1'b1) n_to++;

    lrx_core #(.PATH_LIMIT(20)) u_lrx_core (.*);
    lrx_remote u_lrx_remote (.clk(CLK), .rst(RST), .go(go), .dup_rx(dup), .dly(dly), .disable_port(DISABLE_PORT),
        .link_reset_rx(LINK_RESET_RX), .tx_done(LINK_RESET_TX_DONE), .port_dis(PORT_DISABLED),
        .dis_seen(DISABLE_CHARS_SEEN));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 300)
        begin
            @(posedge CLK);
            #1 n++;
        end
        if (s !== 1'b1)
        begin
            errors++;
            summarize();
        end
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // verdict, alert code, {normal, master, cancel, clear}
    function automatic logic [14:0] exp_chk();
        logic [2:0] v;
        logic [7:0] a;
        logic [3:0] f;
        {v, a, f} = {VD_ACCEPT, 8'h00, 4'h0};
        if (MSG_CODE == 4'hF || !MSG_SUPPORTED || !MSG_FRAME_TYPE_OK) {v, a} = {VD_ALERT, AC_UNKNOWN_MSG};
        else if (MSG_LEN < MSG_MIN_LEN) {v, a} = {VD_ALERT, AC_TOO_SHORT};
        else if (!IS_CONFIGURATOR && !ROUTE_ID_KNOWN) {v, a} = {VD_ALERT, AC_BAD_ROUTE};
        else if (IS_CONFIGURATOR && !TAG_OK) v = VD_DISCARD;
        else if (!IN_CONTEXT) v = IS_CONFIGURATOR ? VD_LOG : VD_DISCARD;
        else if (!RESERVED_SET) f = 4'h8;
        else case (MSG_CODE)
            4'h0: f = 4'h8;
            4'h1: v = VD_NO_REPLY;
            4'h4: {v, f} = {VD_INVALID_FIELD, 4'h4};
            4'h7: {v, f} = {VD_NO_REPLY, 4'h1};
            4'h3, 4'h9, 4'hB: v = VD_DISCARD;
            4'hC, 4'hE: {v, f} = {VD_DISCARD, 4'h2};
            default: v = VD_INVALID_FIELD;
        endcase
        return {v, a, f};
    endfunction
    task automatic send();
        logic [14:0] e;
        MSG_VALID = 1'b1;
        e = exp_chk();
        @(posedge CLK);
        #1 check(CHK_DONE, 1);
        check(CHK_VERDICT, e[14:12]);
        check({CHK_NORMAL_REPLY, CHK_MASTER_ALERT, CHK_CANCEL_IO, CHK_CLEAR_ALERT}, e[3:0]);
        // the code must also read zero whenever no alert is raised
        check(CHK_ALERT_CODE, e[11:4]);
    endtask
    task automatic chk_reset();
        check({OPERATIONAL, PRIVILEGED, CHK_DONE}, 3'b100);
        check({WINDOW_SIZE, ACK_TIMEOUT}, {WINDOW_RESET, ACK_TMO_RESET});
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic run_link(input logic [7:0] d, input logic u, input logic t);
        int s0;
        int t0;
        s0 = n_send;
        t0 = n_to;
        {dly, dup} = {d, u};
        go = 1'b1;
        @(posedge CLK);
        #1 go = 1'b0;
        wait_hi(ENABLE_PORT);
        check(n_send - s0, 1);
        check(n_to != t0, t);
        $display("link walk done, errors=%0d", errors);
    endtask
    task automatic exit_seq(input logic [7:0] c);
        int r0;
        r0 = n_rst;
        {ERP_FAIL_CODE, ERP_FAIL} = {c, 1'b1};
        @(posedge CLK);
        #1 ERP_FAIL = 1'b0;
        repeat (3) @(posedge CLK);
        // a second failure inside the walk is dropped
        #1 {ERP_FAIL_CODE, ERP_FAIL} = {~c, 1'b1};
        @(posedge CLK);
        #1 ERP_FAIL = 1'b0;
        wait_hi(PORT_RESTART);
        repeat (8) @(posedge CLK);
        #1 check({OPERATIONAL, PRIVILEGED}, 2'b01);
        check({WINDOW_SIZE, ACK_TIMEOUT}, {WINDOW_AFTER_EXIT, 16'(ACK_TMO_CYC)});
        check(EXIT_ALERT_CODE, c);
        check(n_rst - r0, 1);
        $display("exit walk done, errors=%0d", errors);
    endtask

    initial
    begin
        repeat (20) @(posedge CLK);
        #1 RST = 1'b0;
        chk_reset();
        run_link(8'd2, 1'b0, 1'b0);
        run_link(8'd3, 1'b1, 1'b0);
        run_link(8'd30, 1'b0, 1'b1);
        exit_seq(8'h5A);
        exit_seq(8'(rnd() >> 24));
        RST = 1'b1;
        repeat (2) @(posedge CLK);
        #1 RST = 1'b0;
        chk_reset();
        exit_seq(8'hA5);
        {MSG_SUPPORTED, MSG_FRAME_TYPE_OK, ROUTE_ID_KNOWN, TAG_OK, IN_CONTEXT, RESERVED_SET} = 6'h3F;
        {MSG_LEN, MSG_MIN_LEN} = {6'h04, 6'h04};
        for (int c = 0; c < 32; c++)
        begin
            {IS_CONFIGURATOR, MSG_CODE} = c[4:0];
            send();
        end
        repeat (400)
        begin
            r = rnd();
            // supported, frame type, route id and tag flags biased high so the deeper checks are reached
            {MSG_CODE, MSG_SUPPORTED, MSG_FRAME_TYPE_OK, ROUTE_ID_KNOWN, TAG_OK, IN_CONTEXT, RESERVED_SET} =
                r[9:0] | {4'h0, r[23:20], 2'b00};
            IS_CONFIGURATOR = r[10];
            MSG_MIN_LEN = r[29:24];
            MSG_LEN = MSG_MIN_LEN + {4'h0, r[31:30]} - 6'h01;
            send();
        end
        // with the enable low the last done flag must hold although the message is gone
        {CE, MSG_VALID} = 2'b00;
        repeat (3) @(posedge CLK);
        #1 check(CHK_DONE, 1);
        CE = 1'b1;
        @(posedge CLK);
        #1 check(CHK_DONE, 0);
        $display("message checks done, errors=%0d", errors);
        summarize();
    end
endmodule
